// ### adcs_pkg.sv
// Package for the converter sequencer control block: offsets, fields, reset values.
// Assumes registers sit one per aligned 32-bit word on AXI4-Lite.
package adcs_pkg;
    // ****************************************
    // Register word indices (bus byte address divided by four)
    // ****************************************
    localparam logic [7:0] ADDR_RESULT_LOW = 8'h20;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h21;
    localparam logic [7:0] ADDR_CONTROL = 8'h22;
    localparam logic [7:0] ADDR_CLOCK = 8'h23;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h24;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h25;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h26;
    localparam int REG_IDX_BITS = 8;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int CTRL_START_BIT = 7;
    localparam int CTRL_DONE_BIT = 6;
    localparam logic [7:0] CTRL_RESET = 8'h40;
    localparam logic [7:0] CLK_RESET = 8'h04;
    localparam logic [7:0] CLK_WRITE_MASK = 8'h83;

    // ****************************************
    // Converter timing
    // ****************************************
    localparam int RESULT_BITS = 9;
    localparam logic [1:0] CLK_DIV2 = 2'h0;
    localparam logic [1:0] CLK_DIV8 = 2'h1;
    localparam logic [1:0] CLK_DIV32 = 2'h2;
    localparam logic [5:0] DIV2_TERM = 6'h01;
    localparam logic [5:0] DIV8_TERM = 6'h07;
    localparam logic [5:0] DIV32_TERM = 6'h1F;
    localparam int CONV_TICKS = 2 * RESULT_BITS; // Settle tick plus decide tick per bit

    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONVERT} adcs_state_t;
endpackage : adcs_pkg

// ### adcs_clkdiv.sv
// Converter clock divider: one-cycle tick at fsys/2, /8 or /32.
// Assumes a synchronous active-low reset on aclk.
`timescale 1ns/1ps
`default_nettype none
module adcs_clkdiv
    import adcs_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic [1:0] clock_sel,
    input wire logic restart,
    // Tick out
    output logic tick
);
    logic [5:0] count;
    logic [5:0] next_count;
    logic [5:0] term;

    // Terminal count by selected source
    always_comb
    begin
        case (clock_sel)
            CLK_DIV2: term = DIV2_TERM;
            CLK_DIV8: term = DIV8_TERM;
            CLK_DIV32: term = DIV32_TERM;
            default: term = DIV32_TERM; // Undefined code runs slowest
        endcase
        tick = (count >= term);
        if (restart || tick)
            next_count = 6'h00;
        else
            next_count = count + 6'h01;
    end

    // Count register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            count <= 6'h00;
        else
            count <= next_count;
    end
endmodule : adcs_clkdiv
`default_nettype wire

// ### adcs_sar.sv
// Successive-approximation step logic: trial bits MSB first, one bit per two ticks.
// Assumes the comparator level is already synchronised to aclk.
`timescale 1ns/1ps
`default_nettype none
module adcs_sar
    import adcs_pkg::*;
#(
    parameter int WIDTH = RESULT_BITS
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic go,
    input wire logic tick,
    input wire logic comp_high,
    // Trial value and completion
    output logic [WIDTH-1:0] trial,
    output logic finished
);
    logic [WIDTH-1:0] mask;
    logic [WIDTH-1:0] next_mask;
    logic [WIDTH-1:0] next_trial;
    logic next_finished;
    logic phase;
    logic next_phase;

    // Settle on one tick, keep or drop trial bit on the next
    always_comb
    begin
        next_mask = mask;
        next_trial = trial;
        next_phase = phase;
        next_finished = 1'b0;
        if (go)
        begin
            next_mask = {1'b1, {(WIDTH-1){1'b0}}};
            next_trial = {1'b1, {(WIDTH-1){1'b0}}};
            next_phase = 1'b0;
        end
        else if (tick && (mask != '0))
        begin
            // Synchronised comparator lags the trial code by two clocks
            next_phase = !phase;
            if (phase)
            begin
                if (!comp_high)
                    next_trial = trial & ~mask;
                next_mask = mask >> 1;
                next_trial = next_trial | (mask >> 1);
                next_finished = (mask[0] == 1'b1);
            end
        end
    end

    // State registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mask <= '0;
            phase <= 1'b0;
            trial <= '0;
            finished <= 1'b0;
        end
        else
        begin
            mask <= next_mask;
            phase <= next_phase;
            trial <= next_trial;
            finished <= next_finished;
        end
    end
endmodule : adcs_sar
`default_nettype wire

// ### adcs_top.sv
// Converter sequencer control: registers over AXI4-Lite, start sequencing, result, interrupt.
// Assumes the analog core gives a comparator level on a pin and takes the trial code.
// Contract
// - Nine-bit result: high byte bits 8..1, low byte bit 7 holds bit 0.
// - Both result registers are read-only; writes leave the result intact.
// - Control bits 2..0 select input 0 to 3; top bit set is unusable.
// - Control bits 5..3 assign zero to four port lines analog; zero powers off.
// - Analog lines lose digital function and pull-up; converter powers up.
// - Start bit rising resets converter and forces done flag to one.
// - Start rising then falling begins conversion on the selected channel.
// - Completion clears done flag and sets the interrupt request flag.
// - Clock register bits 1..0 choose the converter clock source.
// - Clock select codes: 00 fsys/2, 01 fsys/8, 10 fsys/32, 11 undefined.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module adcs_top
    import adcs_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog core
    input wire logic comp_high,
    output logic [RESULT_BITS-1:0] dac_code,
    output logic [3:0] analog_input_sel,
    output logic converter_power,
    output logic test_mode,
    // Port B line control
    output logic [3:0] port_b_analog,
    // Interrupt
    output logic irq
);
    // ****************************************
    // Register state
    // ****************************************
    logic [5:0] cfg, next_cfg;
    logic start_bit, next_start_bit;
    logic done_flag_n, next_done_flag_n;
    logic [7:0] clk_reg, next_clk_reg;
    logic [RESULT_BITS-1:0] result, next_result;
    logic irq_status, next_irq_status;
    logic irq_enable, next_irq_enable;
    adcs_state_t state, next_state;

    // ****************************************
    // Bus slave state
    // ****************************************
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic w_lane0, next_w_lane0;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;

    // Comparator synchroniser
    logic comp_meta;
    logic comp_sync;

    logic do_write;
    logic conv_tick;
    logic sar_go;
    logic sar_done;
    logic [RESULT_BITS-1:0] trial;

    // Address maps to a register
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a >= ADDR_RESULT_LOW) && (a <= ADDR_IRQ_CLEAR);
    endfunction : addr_mapped

    // Register word index of a bus byte address
    function automatic logic [7:0] word_addr(input logic [31:0] a);
        word_addr = a[REG_IDX_BITS+1:2];
    endfunction : word_addr

    // Converter clock divider
    adcs_clkdiv u_clkdiv (
        .aclk(aclk),
        .aresetn(aresetn),
        .clock_sel(clk_reg[1:0]),
        .restart(sar_go),
        .tick(conv_tick)
    );

    // Approximation sequencer
    adcs_sar #(.WIDTH(RESULT_BITS)) u_sar (
        .aclk(aclk),
        .aresetn(aresetn),
        .go(sar_go),
        .tick(conv_tick),
        .comp_high(comp_sync),
        .trial(trial),
        .finished(sar_done)
    );

    // ****************************************
    // AXI4-Lite handshakes
    // ****************************************
    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready = !w_held && !bvalid;
    assign s_axi_arready = !rvalid;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign do_write = aw_held && w_held && !bvalid;

    // Bus channel capture, response and read data
    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_lane0 = w_lane0;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = word_addr(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_lane0 = s_axi_wstrb[0];
        end
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = addr_mapped(aw_addr) ? 2'h0 : 2'h2;
        end
        if (bvalid && s_axi_bready)
            next_bvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = addr_mapped(word_addr(s_axi_araddr)) ? 2'h0 : 2'h2;
            case (word_addr(s_axi_araddr))
                ADDR_RESULT_LOW: next_rdata = {24'h000000, result[0], 7'h00};
                ADDR_RESULT_HIGH: next_rdata = {24'h000000, result[8:1]};
                ADDR_CONTROL: next_rdata = {24'h000000, start_bit, done_flag_n, cfg};
                ADDR_CLOCK: next_rdata = {24'h000000, clk_reg};
                ADDR_IRQ_STATUS: next_rdata = {31'h00000000, irq_status};
                ADDR_IRQ_ENABLE: next_rdata = {31'h00000000, irq_enable};
                default: next_rdata = 32'h00000000;
            endcase
        end
        else if (rvalid && s_axi_rready)
            next_rvalid = 1'b0;
    end

    // ****************************************
    // Control registers and sequencing
    // ****************************************
    always_comb
    begin
        next_cfg = cfg;
        next_start_bit = start_bit;
        next_clk_reg = clk_reg;
        next_irq_enable = irq_enable;
        next_irq_status = irq_status;
        next_done_flag_n = done_flag_n;
        next_result = result;
        next_state = state;
        sar_go = 1'b0;
        // Result registers take no writes
        if (do_write && w_lane0)
        begin
            case (aw_addr)
                ADDR_CONTROL:
                begin
                    next_cfg = w_data[5:0];
                    next_start_bit = w_data[CTRL_START_BIT]; // Done flag bit ignored
                end
                ADDR_CLOCK: next_clk_reg = w_data[7:0] & CLK_WRITE_MASK;
                ADDR_IRQ_ENABLE: next_irq_enable = w_data[0];
                ADDR_IRQ_CLEAR:
                begin
                    if (w_data[0])
                        next_irq_status = 1'b0;
                end
                default: next_cfg = cfg;
            endcase
        end
        // Start rising resets converter, sets done flag
        if (!start_bit && next_start_bit)
        begin
            next_state = ST_ARMED;
            next_done_flag_n = 1'b1;
        end
        else
        begin
            case (state)
                ST_IDLE: next_state = ST_IDLE;
                ST_ARMED:
                begin
                    if (start_bit && !next_start_bit)
                    begin
                        sar_go = 1'b1;
                        next_state = ST_CONVERT;
                    end
                end
                ST_CONVERT:
                begin
                    if (sar_done)
                    begin
                        next_result = trial;
                        next_done_flag_n = 1'b0;
                        next_irq_status = 1'b1;
                        next_state = ST_IDLE;
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    // Register updates
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg <= CTRL_RESET[5:0];
            start_bit <= CTRL_RESET[CTRL_START_BIT];
            done_flag_n <= CTRL_RESET[CTRL_DONE_BIT];
            clk_reg <= CLK_RESET;
            result <= '0;
            irq_status <= 1'b0;
            irq_enable <= 1'b0;
            state <= ST_IDLE;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_lane0 <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= 2'h0;
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
        end
        else
        begin
            cfg <= next_cfg;
            start_bit <= next_start_bit;
            done_flag_n <= next_done_flag_n;
            clk_reg <= next_clk_reg;
            result <= next_result;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            state <= next_state;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_lane0 <= next_w_lane0;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            comp_meta <= comp_high;
            comp_sync <= comp_meta;
        end
    end

    // ****************************************
    // Analog side outputs
    // ****************************************
    // Port lines made analog by assignment code
    always_comb
    begin
        if (cfg[5])
            port_b_analog = 4'hF;
        else
            case (cfg[4:3])
                2'h1: port_b_analog = 4'h1;
                2'h2: port_b_analog = 4'h3;
                2'h3: port_b_analog = 4'h7;
                default: port_b_analog = 4'h0;
            endcase
    end

    // Channel one-hot; top bit set selects none
    always_comb
    begin
        analog_input_sel = 4'h0;
        if (!cfg[2])
            analog_input_sel[cfg[1:0]] = 1'b1;
    end

    assign converter_power = (port_b_analog != 4'h0);
    assign dac_code = trial;
    assign test_mode = clk_reg[7];
    assign irq = irq_status && irq_enable;
endmodule : adcs_top
`default_nettype wire

// ### adcs_checker.sv
// Concurrent checks on the converter control block top-level ports.
// Assumes one clock domain, aclk, with synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module adcs_checker
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Converter side
    input wire logic [3:0] analog_input_sel,
    input wire logic converter_power,
    input wire logic [3:0] port_b_analog
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Address and data accepted at one edge
    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    a_write_answer: assert property (write_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_rdata_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    a_power_lines: assert property (converter_power == (port_b_analog != 4'h0))
        else $error("converter power disagrees with analog lines");
    a_lines_fill: assert property (port_b_analog inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
        else $error("analog lines not filled from line 0");
    a_sel_onehot: assert property ($onehot0(analog_input_sel))
        else $error("more than one input selected");
endmodule : adcs_checker
`default_nettype wire

bind adcs_top adcs_checker u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .analog_input_sel(analog_input_sel), .converter_power(converter_power),
    .port_b_analog(port_b_analog));

// ### adcs_analog_model.sv
// Behavioural analog front end: four input levels and a comparator.
// Assumes one-hot channel select and the trial code from the block.
`timescale 1ns/1ps
`default_nettype none
module adcs_analog_model
    import adcs_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Levels, channel i in bits 9i+8..9i
    input wire logic [35:0] levels,
    // From the block
    input wire logic [3:0] analog_input_sel,
    input wire logic [RESULT_BITS-1:0] dac_code,
    // To the block
    output logic comp_high
);
    logic [8:0] level;
    logic scramble = 1'b0;

    // Unselected comparator gives a changing level
    always @(posedge aclk)
        scramble <= !scramble;

    // Compare the selected channel with the trial code
    always_comb
    begin
        level = 9'h000;
        for (int i = 0; i < 4; i++)
            if (analog_input_sel[i]) level = levels[i*9 +: 9];
        comp_high = (analog_input_sel != 4'h0) ? (level >= dac_code) : scramble;
    end
endmodule : adcs_analog_model
`default_nettype wire

// ### tb.sv
// Self-checking bench for the converter control block.
// Assumes the analog model on the comparator side and an AXI4-Lite master here.
`timescale 1ns/1ps
`default_nettype none
module tb
    import adcs_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, comp_high, power, test_mode, irq;
    logic [1:0] bresp, rresp;
    logic [8:0] dac_code;
    logic [3:0] sel, port_b;
    logic [35:0] levels = 36'h0;
    int n_fail = 0, n_tests = 0, cycles = 0;

    adcs_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .comp_high(comp_high), .dac_code(dac_code),
        .analog_input_sel(sel), .converter_power(power), .test_mode(test_mode),
        .port_b_analog(port_b), .irq(irq));

    adcs_analog_model u_analog (.aclk(aclk), .levels(levels), .analog_input_sel(sel),
        .dac_code(dac_code), .comp_high(comp_high));

    // ****************************************
    // Clock, timeout and shared tasks
    // ****************************************
    initial
        forever #10 aclk = !aclk;

    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_fail++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask : chk

    // Word index to byte address; handshakes judged at the rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        bit got_b;
        got_b = 1'b0;
        awaddr <= {22'h0, a, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!got_b)
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            got_b = bvalid && bready;
            r = bresp;
        end
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit got_r;
        got_r = 1'b0;
        araddr <= {22'h0, a, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got_r)
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            got_r = rvalid && rready;
            d = rdata;
            r = rresp;
        end
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    task automatic complete_run;
        if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic reset_and_map;
        logic [31:0] d;
        logic [1:0] r;
        rd(ADDR_CONTROL, d, r);
        chk(d, {24'h0, CTRL_RESET});
        rd(ADDR_CLOCK, d, r);
        chk(d, {24'h0, CLK_RESET});
        rd(8'h27, d, r);
        chk(r, 2'h2);
        wr(8'h27, 8'h01, r);
        chk(r, 2'h2);
        chk(irq, 1'b0);
        wr(ADDR_CLOCK, 8'h7F, r);
        rd(ADDR_CLOCK, d, r);
        chk(d, 32'h03);
        chk(test_mode, 1'b0);
    endtask : reset_and_map

    task automatic port_lines;
        logic [1:0] r;
        for (int i = 0; i < 8; i++)
        begin
            wr(ADDR_CONTROL, {2'b00, 3'(i), 3'(i)}, r);
            chk(port_b, (i >= 4) ? 4'hF : 4'((1 << i) - 1));
            chk(power, i != 0);
            chk(sel, (i < 4) ? 4'(1 << i) : 4'h0);
        end
    endtask : port_lines

    task automatic convert(input logic [1:0] code, input logic [1:0] ch, input logic [8:0] v,
                           input logic en);
        logic [31:0] d;
        logic [1:0] r;
        int k;
        int div;
        div = (code == CLK_DIV2) ? 2 : ((code == CLK_DIV8) ? 8 : 32);
        levels[ch*9 +: 9] <= v;
        wr(ADDR_IRQ_ENABLE, {7'h0, en}, r);
        wr(ADDR_CLOCK, {6'h0, code}, r);
        wr(ADDR_CONTROL, 8'hA0 | {6'h0, ch}, r);
        rd(ADDR_CONTROL, d, r);
        chk(d, 32'hE0 | ch);
        wr(ADDR_CONTROL, 8'h60 | {6'h0, ch}, r);
        k = 0;
        d = 32'h0;
        if (en)
        begin
            while (irq !== 1'b1 && k < 1000)
            begin
                @(posedge aclk);
                k++;
            end
            chk(k >= CONV_TICKS * div && k <= CONV_TICKS * div + 4, 1'b1);
        end
        else
            while (d[0] !== 1'b1 && k < 400)
            begin
                rd(ADDR_IRQ_STATUS, d, r);
                k++;
            end
        rd(ADDR_CONTROL, d, r);
        chk(d, 32'h20 | ch);
        rd(ADDR_RESULT_HIGH, d, r);
        chk(d, {24'h0, v[8:1]});
        rd(ADDR_RESULT_LOW, d, r);
        chk(d, {24'h0, v[0], 7'h0});
        chk(irq, en);
        wr(ADDR_IRQ_ENABLE, 8'h01, r);
        chk(irq, 1'b1);
        wr(ADDR_IRQ_CLEAR, 8'h01, r);
        rd(ADDR_IRQ_STATUS, d, r);
        chk({irq, d[0]}, 2'b00);
    endtask : convert

    task automatic result_read_only;
        logic [31:0] d;
        logic [1:0] r;
        wr(ADDR_RESULT_HIGH, 8'hFF, r);
        chk(r, 2'h0);
        wr(ADDR_RESULT_LOW, 8'h00, r);
        rd(ADDR_RESULT_HIGH, d, r);
        chk(d, 32'h00);
        rd(ADDR_RESULT_LOW, d, r);
        chk(d, 32'h80);
        wstrb <= 4'hE;
        wr(ADDR_CONTROL, 8'h07, r);
        wstrb <= 4'hF;
        rd(ADDR_CONTROL, d, r);
        chk(d, 32'h21);
    endtask : result_read_only

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        reset_and_map();
        port_lines();
        convert(CLK_DIV2, 2'd0, 9'h155, 1'b1);
        convert(CLK_DIV8, 2'd3, 9'h0AA, 1'b1);
        convert(CLK_DIV32, 2'd2, 9'h1FF, 1'b1);
        convert(2'h3, 2'd1, 9'h001, 1'b0);
        result_read_only();
        complete_run();
    end
endmodule : tb
`default_nettype wire
